// >>> rtl/afe_ctrl_consts.svh
`ifndef AFE_CTRL_CONSTS_SVH
`define AFE_CTRL_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets, reset value and writable bits
// ---------------------------------------------------------------
`define OFS_EN_A     8'h06
`define OFS_EN_B     8'h07
`define OFS_CTRL     8'h08
`define OFS_PIN_MUX  8'h0b
`define OFS_GAS      8'h0c
`define REG_RESET    8'h00
`define WMASK_EN_A   8'h2d
`define WMASK_EN_B   8'h86
`define WMASK_CTRL   8'h3e
`define WMASK_PIN    8'hb7
`define WMASK_GAS    8'hf0

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define B_RX_ON      5
`define B_PAMP_ON    3
`define B_PGAIN_ON   2
`define B_LEDREG_ON  0
`define B_LED_SEL    7
`define B_LED_GATE   2
`define B_TX_ON      1
`define B_HOSTREG_OFF 5
`define B_BROWN_OFF  4
`define B_HOSTERR_OFF 3
`define B_OT_ON      2
`define B_SOFT_RST   1
`define B_MUX_BYP    7
`define F_MUX_SEL    5:4
`define F_PIN_FN     2:0
`define B_GAS_RO     7
`define B_GAS_RG     6
`define B_GAS_RI     5
`define B_GAS_REF    4

// ---------------------------------------------------------------
// Codes and counts
// ---------------------------------------------------------------
`define MUX_OFF      2'h0
`define PIN_HIZ      3'h0
`define PIN_ERR      3'h2
`define PIN_LED_A    3'h4
`define PIN_LED_B    3'h5
`define BITS_BYTE    4'h8
`define DEV_ADDR     7'h2a
`endif

// >>> rtl/afe_ctrl_pkg.sv
package afe_ctrl_pkg;
    // Serial slave phases
    typedef enum logic [2:0] {
        st_idle, st_addr, st_reg, st_wdata, st_ack, st_rdata, st_rack
    } bus_st_t;

    // Synchronised pin group
    typedef struct packed {
        logic host_err;
        logic overtemp;
        logic gpio;
        logic led_pin;
        logic led_b;
        logic led_a;
        logic sda;
        logic scl;
    } pins_t;

    // The five control registers
    typedef struct packed {
        logic [7:0] en_a;
        logic [7:0] en_b;
        logic [7:0] ctrl;
        logic [7:0] pin_mux;
        logic [7:0] gas;
    } ctrl_regs_t;

    // Controls to the analog blocks
    typedef struct packed {
        logic       loop_tx_en;
        logic       loop_rx_en;
        logic       photo_in_amp_en;
        logic       photo_gain_amp_en;
        logic       led_reg_en;
        logic       host_reg_en;
        logic       brownout_mon_en;
        logic [1:0] mux_sel;
        logic       mux_buf_en;
        logic       mux_bypass_sw;
        logic       gas_out_res;
        logic       gas_fb_close;
        logic       gas_in_res;
        logic       gas_ref_int;
        logic       led_a_on;
        logic       led_b_on;
        logic       fault_enter;
        logic       overtemp_error_set;
    } analog_ctl_t;

    // Whole module state
    typedef struct packed {
        pins_t       s1;
        pins_t       s2;
        pins_t       s3;
        pins_t       filt;
        pins_t       filt_d;
        ctrl_regs_t  regs;
        bus_st_t     st;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [7:0]  ptr;
        logic        rw;
        logic        got_reg;
        logic        nack;
        logic        sda_oe;
        logic        gpio_out;
        logic        gpio_oe;
        analog_ctl_t ctl;
    } state_t;
endpackage

// >>> rtl/afe_enable_control_regs.sv
`timescale 1ns/1ps
`include "afe_ctrl_consts.svh"

module afe_enable_control_regs
    import afe_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Two-wire serial bus
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output      logic        sda_o,
    output      logic        sda_oe,
    // Device pins
    input  wire logic        led_a_enable_in,
    input  wire logic        led_b_enable_in,
    input  wire logic        led_enable_in,
    input  wire logic        gpio_i,
    output      logic        gpio_o,
    output      logic        gpio_oe,
    // Events from the analog side
    input  wire logic        overtemp_in,
    input  wire logic        host_reg_pg_err_in,
    // Status and mask from the neighbouring bank
    input  wire logic [7:0]  first_status_reg,
    input  wire logic [7:0]  status_mask,
    // Analog controls
    output      analog_ctl_t ctl
);

    state_t r_r;
    state_t r_nxt;
    pins_t  pins;
    logic   scl_rise;
    logic   scl_fall;
    logic   start_c;
    logic   stop_c;

    // ---------------------------------------------------------------
    // Pin capture
    // ---------------------------------------------------------------
    assign pins.scl      = scl_i;
    assign pins.sda      = sda_i;
    assign pins.led_a    = led_a_enable_in;
    assign pins.led_b    = led_b_enable_in;
    assign pins.led_pin  = led_enable_in;
    assign pins.gpio     = gpio_i;
    assign pins.overtemp = overtemp_in;
    assign pins.host_err = host_reg_pg_err_in;

    // Bus events from filtered lines
    assign scl_rise = r_r.filt.scl & ~r_r.filt_d.scl;
    assign scl_fall = ~r_r.filt.scl & r_r.filt_d.scl;
    assign start_c  = r_r.filt.scl & r_r.filt_d.scl
                      & ~r_r.filt.sda & r_r.filt_d.sda;
    assign stop_c   = r_r.filt.scl & r_r.filt_d.scl
                      & r_r.filt.sda & ~r_r.filt_d.sda;

    // Read multiplexer; unmapped offsets read zero
    function automatic logic [7:0] rd_reg(input ctrl_regs_t g,
                                          input logic [7:0]  a);
        logic [7:0] v;
        v = `REG_RESET;
        case (a)
            `OFS_EN_A:    v = g.en_a;
            `OFS_EN_B:    v = g.en_b;
            `OFS_CTRL:    v = g.ctrl;
            `OFS_PIN_MUX: v = g.pin_mux;
            `OFS_GAS:     v = g.gas;
            default:      v = `REG_RESET;
        endcase
        return v;
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        logic [7:0]  unmasked;
        logic [2:0]  fn;
        logic        sel_led;
        logic [7:0]  rd;
        ctrl_regs_t  g;
        r_nxt    = r_r;
        unmasked = '0;
        fn       = '0;
        sel_led  = 1'b0;
        rd       = '0;
        g        = r_r.regs;

        // Three-stage capture; accept only when stages two and three agree
        r_nxt.s1     = pins;
        r_nxt.s2     = r_r.s1;
        r_nxt.s3     = r_r.s2;
        r_nxt.filt   = (r_r.s2 ~^ r_r.s3) & r_r.s3
                     | (r_r.s2 ^ r_r.s3) & r_r.filt;
        r_nxt.filt_d = r_r.filt;

        // Serial slave; start and stop override any phase
        if (start_c)
        begin
            r_nxt.st      = st_addr;
            r_nxt.cnt     = '0;
            r_nxt.got_reg = 1'b0;
            r_nxt.sda_oe  = 1'b0;
        end
        else if (stop_c)
        begin
            r_nxt.st     = st_idle;
            r_nxt.sda_oe = 1'b0;
        end
        else
        begin
            case (r_r.st)
                st_addr, st_reg, st_wdata:
                begin
                    if (scl_rise)
                    begin
                        r_nxt.sh  = {r_r.sh[6:0], r_r.filt.sda};
                        r_nxt.cnt = r_r.cnt + 4'h1;
                    end
                    else if (scl_fall && r_r.cnt == `BITS_BYTE)
                    begin
                        r_nxt.st     = st_ack;
                        r_nxt.sda_oe = 1'b1;
                        if (r_r.st == st_addr)
                        begin
                            r_nxt.rw = r_r.sh[0];
                            if (r_r.sh[7:1] != `DEV_ADDR)
                            begin
                                r_nxt.st     = st_idle;
                                r_nxt.sda_oe = 1'b0;
                            end
                        end
                        else if (r_r.st == st_reg)
                        begin
                            r_nxt.ptr     = r_r.sh;
                            r_nxt.got_reg = 1'b1;
                        end
                        else
                        begin
                            // Reserved bits stay zero on write
                            case (r_r.ptr)
                                `OFS_EN_A:
                                    g.en_a = r_r.sh & `WMASK_EN_A;
                                `OFS_EN_B:
                                    g.en_b = r_r.sh & `WMASK_EN_B;
                                `OFS_CTRL:
                                    g.ctrl = r_r.sh & `WMASK_CTRL;
                                `OFS_PIN_MUX:
                                    g.pin_mux = r_r.sh & `WMASK_PIN;
                                `OFS_GAS:
                                    g.gas = r_r.sh & `WMASK_GAS;
                                default:
                                    g = r_r.regs;
                            endcase
                            // Soft reset clears the whole bank, itself too
                            if (g.ctrl[`B_SOFT_RST])
                                g = '0;
                            r_nxt.regs = g;
                            r_nxt.ptr  = r_r.ptr + 8'h01;
                        end
                    end
                end
                st_ack:
                begin
                    if (scl_fall)
                    begin
                        r_nxt.cnt    = '0;
                        r_nxt.sda_oe = 1'b0;
                        if (r_r.rw)
                        begin
                            rd           = rd_reg(r_r.regs, r_r.ptr);
                            r_nxt.sh     = rd;
                            r_nxt.sda_oe = ~rd[7];
                            r_nxt.st     = st_rdata;
                        end
                        else if (r_r.got_reg)
                            r_nxt.st = st_wdata;
                        else
                            r_nxt.st = st_reg;
                    end
                end
                st_rdata:
                begin
                    if (scl_fall)
                    begin
                        r_nxt.cnt = r_r.cnt + 4'h1;
                        r_nxt.sh  = {r_r.sh[6:0], 1'b0};
                        if (r_r.cnt == `BITS_BYTE - 4'h1)
                        begin
                            r_nxt.sda_oe = 1'b0;
                            r_nxt.st     = st_rack;
                            r_nxt.ptr    = r_r.ptr + 8'h01;
                        end
                        else
                            r_nxt.sda_oe = ~r_r.sh[6];
                    end
                end
                st_rack:
                begin
                    if (scl_rise)
                        r_nxt.nack = r_r.filt.sda;
                    else if (scl_fall)
                    begin
                        // Host acknowledge continues with the next offset
                        if (r_r.nack)
                            r_nxt.st = st_idle;
                        else
                        begin
                            rd           = rd_reg(r_r.regs, r_r.ptr);
                            r_nxt.sh     = rd;
                            r_nxt.sda_oe = ~rd[7];
                            r_nxt.cnt    = '0;
                            r_nxt.st     = st_rdata;
                        end
                    end
                end
                default:
                    r_nxt.sda_oe = 1'b0;
            endcase
        end

        // Controls follow the registers one cycle after a write
        r_nxt.ctl.loop_rx_en        = r_r.regs.en_a[`B_RX_ON];
        r_nxt.ctl.photo_in_amp_en   = r_r.regs.en_a[`B_PAMP_ON];
        r_nxt.ctl.photo_gain_amp_en = r_r.regs.en_a[`B_PGAIN_ON];
        r_nxt.ctl.led_reg_en        = r_r.regs.en_a[`B_LEDREG_ON];
        r_nxt.ctl.loop_tx_en        = r_r.regs.en_b[`B_TX_ON];
        r_nxt.ctl.host_reg_en  = ~r_r.regs.ctrl[`B_HOSTREG_OFF];
        r_nxt.ctl.brownout_mon_en = ~r_r.regs.ctrl[`B_BROWN_OFF];

        // Mux: buffer or low-resistance switch, only when selected
        r_nxt.ctl.mux_sel = r_r.regs.pin_mux[`F_MUX_SEL];
        r_nxt.ctl.mux_buf_en =
            (r_r.regs.pin_mux[`F_MUX_SEL] != `MUX_OFF)
            & ~r_r.regs.pin_mux[`B_MUX_BYP];
        r_nxt.ctl.mux_bypass_sw =
            (r_r.regs.pin_mux[`F_MUX_SEL] != `MUX_OFF)
            & r_r.regs.pin_mux[`B_MUX_BYP];

        // Gas amplifier switches
        r_nxt.ctl.gas_out_res  = r_r.regs.gas[`B_GAS_RO];
        r_nxt.ctl.gas_fb_close = r_r.regs.gas[`B_GAS_RG];
        r_nxt.ctl.gas_in_res   = r_r.regs.gas[`B_GAS_RI];
        r_nxt.ctl.gas_ref_int  = r_r.regs.gas[`B_GAS_REF];

        // LED enables: gated pin picks source, pin modes OR in
        fn      = r_r.regs.pin_mux[`F_PIN_FN];
        sel_led = r_r.regs.en_b[`B_LED_SEL];
        r_nxt.ctl.led_a_on =
            (r_r.regs.en_b[`B_LED_GATE] & r_r.filt.led_pin
             & ~sel_led & r_r.filt.led_a)
            | ((fn == `PIN_LED_A)
               & (r_r.filt.gpio | r_r.filt.led_a));
        r_nxt.ctl.led_b_on =
            (r_r.regs.en_b[`B_LED_GATE] & r_r.filt.led_pin
             & sel_led & r_r.filt.led_b)
            | ((fn == `PIN_LED_B)
               & (r_r.filt.gpio | r_r.filt.led_b));

        // Fault policy
        r_nxt.ctl.overtemp_error_set =
            r_r.filt.overtemp & r_r.regs.ctrl[`B_OT_ON];
        r_nxt.ctl.fault_enter =
            (r_r.filt.host_err & ~r_r.regs.ctrl[`B_HOSTERR_OFF])
            | (r_r.filt.overtemp & r_r.regs.ctrl[`B_OT_ON]);

        // Multi-purpose pin; reserved codes leave it released
        unmasked = first_status_reg & ~status_mask;
        r_nxt.gpio_oe  = (fn == `PIN_ERR);
        r_nxt.gpio_out = (fn == `PIN_ERR) & (|unmasked);
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            r_r                     <= '0;
            r_r.s1                  <= '1; // Idle bus lines high
            r_r.s2                  <= '1;
            r_r.s3                  <= '1;
            r_r.filt                <= '1;
            r_r.filt_d              <= '1;
            r_r.st                  <= st_idle;
            r_r.ctl.host_reg_en     <= 1'b1;
            r_r.ctl.brownout_mon_en <= 1'b1;
        end
        else
            r_r <= r_nxt;
    end

    // ---------------------------------------------------------------
    // Outputs, all from flip-flops
    // ---------------------------------------------------------------
    assign sda_o   = r_r.gpio_out & 1'b0; // Open drain: only pulls low
    assign sda_oe  = r_r.sda_oe;
    assign gpio_o  = r_r.gpio_out;
    assign gpio_oe = r_r.gpio_oe;
    assign ctl     = r_r.ctl;

endmodule

// >>> tb/afe_enable_control_regs_asserts.sv
`timescale 1ns/1ps

module afe_enable_control_regs_checker
    import afe_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Bus and pins
    input wire logic        scl_i,
    input wire logic        sda_oe,
    input wire logic        led_a_enable_in,
    input wire logic        led_b_enable_in,
    input wire logic        gpio_i,
    input wire logic        gpio_o,
    input wire logic        gpio_oe,
    // Events and status
    input wire logic        overtemp_in,
    input wire logic        host_reg_pg_err_in,
    input wire logic [7:0]  first_status_reg,
    input wire logic [7:0]  status_mask,
    // Analog controls
    input wire analog_ctl_t ctl
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_reset_ctl;
        $rose(rst_n) |-> ctl.host_reg_en && ctl.brownout_mon_en
            && !ctl.loop_tx_en && !ctl.fault_enter && !gpio_oe && !sda_oe;
    endproperty
    a_reset_ctl: assert property (p_reset_ctl)
        else $error("controls not at reset values");

    property p_mux_off;
        ctl.mux_sel == 2'h0 |-> !ctl.mux_buf_en && !ctl.mux_bypass_sw;
    endproperty
    a_mux_off: assert property (p_mux_off)
        else $error("mux path active while off");

    property p_mux_one;
        ctl.mux_sel != 2'h0 |-> ctl.mux_buf_en != ctl.mux_bypass_sw;
    endproperty
    a_mux_one: assert property (p_mux_one)
        else $error("mux needs exactly one of buffer or switch");

    // Error summary lags the status inputs by one clock
    property p_gpio_err;
        gpio_oe && $past(gpio_oe) |->
            gpio_o == |($past(first_status_reg) & ~$past(status_mask));
    endproperty
    a_gpio_err: assert property (p_gpio_err)
        else $error("error pin does not match unmasked status");

    property p_ot_fault;
        ctl.overtemp_error_set |-> ctl.fault_enter;
    endproperty
    a_ot_fault: assert property (p_ot_fault)
        else $error("overtemp flag without fault");

    property p_no_ot;
        (!overtemp_in)[*8] |-> !ctl.overtemp_error_set;
    endproperty
    a_no_ot: assert property (p_no_ot)
        else $error("overtemp flag without event");

    property p_no_fault;
        (!overtemp_in && !host_reg_pg_err_in)[*8] |-> !ctl.fault_enter;
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("fault without any event");

    property p_led_a;
        (!led_a_enable_in && !gpio_i)[*8] |-> !ctl.led_a_on;
    endproperty
    a_led_a: assert property (p_led_a)
        else $error("led a on without source");

    property p_led_b;
        (!led_b_enable_in && !gpio_i)[*8] |-> !ctl.led_b_on;
    endproperty
    a_led_b: assert property (p_led_b)
        else $error("led b on without source");

    // Device may only move the data line while the clock is low
    property p_bus_phase;
        $changed(sda_oe) |-> !scl_i;
    endproperty
    a_bus_phase: assert property (p_bus_phase)
        else $error("data line moved with clock high");
endmodule

// >>> tb/afe_enable_control_regs_tb_top.sv
`timescale 1ns/1ps
`include "afe_ctrl_consts.svh"

module afe_enable_control_regs_tb_top
    import afe_ctrl_pkg::*;
;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic        mclk, rst_n, scl, sda_low, sda_wire, sda_o, sda_oe;
    logic        led_a, led_b, led_en, gpio_i, gpio_o, gpio_oe;
    logic        ot, herr;
    logic [7:0]  status, mask;
    analog_ctl_t ctl;
    int          n_mismatch = 0;
    int          check_count = 0;
    localparam logic [7:0] OFS [5] = '{`OFS_EN_A, `OFS_EN_B, `OFS_CTRL,
                                       `OFS_PIN_MUX, `OFS_GAS};
    localparam logic [7:0] WM [5] = '{`WMASK_EN_A, `WMASK_EN_B,
                                      `WMASK_CTRL, `WMASK_PIN, `WMASK_GAS};

    // Open-drain line with pull-up
    assign sda_wire = !(sda_low | sda_oe);

    afe_enable_control_regs u_afe_enable_control_regs (
        .mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe(sda_oe), .led_a_enable_in(led_a),
        .led_b_enable_in(led_b), .led_enable_in(led_en), .gpio_i(gpio_i),
        .gpio_o(gpio_o), .gpio_oe(gpio_oe), .overtemp_in(ot),
        .host_reg_pg_err_in(herr), .first_status_reg(status),
        .status_mask(mask), .ctl(ctl));

    afe_host_model u_afe_host_model (
        .mclk(mclk), .sda_in(sda_wire), .scl(scl), .sda_low(sda_low));

    always #2.5 mclk = ~mclk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, {7'h0, e}, {7'h0, g});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        u_afe_host_model.wr(a, d, ok);
        chkb("write ack", 1'b1, ok);
        repeat (8) @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic ok;
        u_afe_host_model.rd(a, q, ok);
        chkb("read ack", 1'b1, ok);
        chk("register", e, q);
    endtask

    // Pins change on the clock edge, then the filter settles
    task automatic pins(input logic [5:0] v);
        @(posedge mclk);
        {led_a, led_b, led_en, gpio_i, ot, herr} <= v;
        repeat (12) @(posedge mclk);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_access();
        foreach (OFS[i]) rd(OFS[i], 8'h00);
        foreach (OFS[i]) wr(OFS[i], i == 2 ? 8'hfd : 8'hff);
        foreach (OFS[i]) rd(OFS[i], WM[i] & (i == 2 ? 8'hfd : 8'hff));
        rd(8'h09, 8'h00);
        chk("enables", 8'h1f, {3'h0, ctl.loop_tx_en, ctl.loop_rx_en,
            ctl.photo_in_amp_en, ctl.photo_gain_amp_en, ctl.led_reg_en});
        chk("supplies", 8'h00, {6'h0, ctl.host_reg_en,
            ctl.brownout_mon_en});
        chk("gas", 8'h0f, {4'h0, ctl.gas_out_res, ctl.gas_fb_close,
            ctl.gas_in_res, ctl.gas_ref_int});
        chk("bypass", 8'h0e, {4'h0, ctl.mux_sel, ctl.mux_bypass_sw,
            ctl.mux_buf_en});
        chkb("reserved mode oe", 1'b0, gpio_oe);
        chkb("data line level", 1'b0, sda_o);
        wr(`OFS_CTRL, 8'h02);
        foreach (OFS[i]) rd(OFS[i], 8'h00);
        chkb("host reg after soft reset", 1'b1, ctl.host_reg_en);
        $display("access test done");
    endtask

    task automatic t_mux();
        for (int s = 0; s < 4; s++)
        begin
            wr(`OFS_PIN_MUX, {2'h0, s[1:0], 4'h0});
            chk("mux", {5'h0, s[1:0], s != 0},
                {5'h0, ctl.mux_sel, ctl.mux_buf_en});
        end
        $display("mux test done");
    endtask

    task automatic t_gpio();
        wr(`OFS_PIN_MUX, {5'h0, `PIN_ERR});
        @(posedge mclk);
        status <= 8'h10;
        repeat (3) @(posedge mclk);
        chk("error pin", 8'h03, {6'h0, gpio_oe, gpio_o});
        mask <= 8'h10;
        repeat (3) @(posedge mclk);
        chkb("masked error pin", 1'b0, gpio_o);
        wr(`OFS_PIN_MUX, {5'h0, `PIN_HIZ});
        chkb("hiz oe", 1'b0, gpio_oe);
        $display("gpio test done");
    endtask

    task automatic t_led();
        wr(`OFS_PIN_MUX, {5'h0, `PIN_LED_A});
        pins(6'b000100);
        chkb("led a by pin", 1'b1, ctl.led_a_on);
        pins(6'b100000);
        chkb("led a by input", 1'b1, ctl.led_a_on);
        wr(`OFS_PIN_MUX, {5'h0, `PIN_LED_B});
        pins(6'b010000);
        chk("led b mode", 8'h01, {6'h0, ctl.led_a_on, ctl.led_b_on});
        wr(`OFS_PIN_MUX, 8'h00);
        chkb("led b ungated", 1'b0, ctl.led_b_on);
        wr(`OFS_EN_B, 8'h04);
        pins(6'b101000);
        chkb("gated led a", 1'b1, ctl.led_a_on);
        wr(`OFS_EN_B, 8'h84);
        pins(6'b011000);
        chk("gated led b", 8'h01, {6'h0, ctl.led_a_on, ctl.led_b_on});
        wr(`OFS_EN_B, 8'h00);
        pins(6'b000000);
        $display("led test done");
    endtask

    task automatic t_fault();
        pins(6'b000001);
        chkb("host error fault", 1'b1, ctl.fault_enter);
        wr(`OFS_CTRL, 8'h08);
        chkb("host error fault off", 1'b0, ctl.fault_enter);
        pins(6'b000010);
        chk("overtemp off", 8'h00,
            {6'h0, ctl.fault_enter, ctl.overtemp_error_set});
        wr(`OFS_CTRL, 8'h04);
        chk("overtemp on", 8'h03,
            {6'h0, ctl.fault_enter, ctl.overtemp_error_set});
        pins(6'b000000);
        $display("fault test done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        {led_a, led_b, led_en, gpio_i, ot, herr} = 6'h0;
        status = 8'h00;
        mask = 8'h00;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_access();
        t_mux();
        t_gpio();
        t_led();
        t_fault();
        summarize();
    end

    initial
    begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        summarize();
    end
endmodule

bind afe_enable_control_regs afe_enable_control_regs_checker
    u_afe_enable_control_regs_checker (
    .mclk(mclk), .rst_n(rst_n), .scl_i(scl_i), .sda_oe(sda_oe),
    .led_a_enable_in(led_a_enable_in), .led_b_enable_in(led_b_enable_in),
    .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .overtemp_in(overtemp_in), .host_reg_pg_err_in(host_reg_pg_err_in),
    .first_status_reg(first_status_reg), .status_mask(status_mask),
    .ctl(ctl));

// >>> tb/afe_host_model.sv
`timescale 1ns/1ps
`include "afe_ctrl_consts.svh"

module afe_host_model
(
    // Clock
    input  wire logic mclk,
    // Wire level and drivers
    input  wire logic sda_in,
    output      logic scl,
    output      logic sda_low
);
    // ----------------------------------------
    // Bus phases
    // ----------------------------------------
    // Quarter bit is 8 clocks so the device filter always catches up
    localparam int Q = 8;

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Start or repeated start, clock left low
    task automatic start();
        tick(Q); sda_low <= 1'b0; tick(Q); scl <= 1'b1; tick(Q);
        sda_low <= 1'b1; tick(Q); scl <= 1'b0;
    endtask

    task automatic stop();
        tick(Q); sda_low <= 1'b1; tick(Q); scl <= 1'b1; tick(Q);
        sda_low <= 1'b0; tick(Q);
    endtask

    // Data changes mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic rb);
        tick(Q); sda_low <= !b; tick(Q); scl <= 1'b1; tick(Q);
        rb = sda_in; tick(Q); scl <= 1'b0;
    endtask

    // Byte MSB first, then the ninth bit
    task automatic xfer(input logic [7:0] d, input logic nb,
                        output logic [7:0] q, output logic ack_low);
        logic rb;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(d[i], rb);
            q[i] = rb;
        end
        bit_io(nb, rb);
        ack_low = !rb;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic k0, k1, k2;
        start();
        xfer({`DEV_ADDR, 1'b0}, 1'b1, q, k0);
        xfer(a, 1'b1, q, k1);
        xfer(d, 1'b1, q, k2);
        stop();
        ok = k0 & k1 & k2;
    endtask

    // Pointer write, repeated start, one byte with host NACK
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic k0, k1, k2, k3;
        start();
        xfer({`DEV_ADDR, 1'b0}, 1'b1, q, k0);
        xfer(a, 1'b1, q, k1);
        start();
        xfer({`DEV_ADDR, 1'b1}, 1'b1, q, k2);
        xfer(8'hff, 1'b1, d, k3);
        stop();
        ok = k0 & k1 & k2;
    endtask
endmodule
